// file: hdl/imsw_cfg_top.sv
/*
 * imsw_cfg_top: register front end for the interpolation rate selection
 * and the paged modulator switch setup, with the switch datapath itself.
 * assumes: a plain register port on ref_clk (one-cycle strobes, read data
 * in the cycle after the read strobe) and nco results on the same clock.
 */
// The implementer's own choice: the address-and-strobe port.
// Operation
// - channel rate field selects channelizer interpolation
// - main rate field selects main interpolation
// - flag unsupported link mode and rate pairing
// - complex bit set forces route mode 0b11
// - complex bit clear: route follows mode only
// - complex, nco1 on: summed i and q
// - complex, nco1 off: nco0 i and q
// - mode 00 routes i0 and i1
// - mode 01 sums i paths and q paths
// - mode 10 routes i0 and q0
// - mode 11 sums i, dac1 held zero
// - nco enable bit gates main nco
// - bit two enables modulus synthesizer
// - sideband zero keeps upper sideband
// - sideband one keeps lower, inverted spectrum
// - switch fields banked by page select
module imsw_cfg_top
	import imsw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [IMSW_AW-1:0] reg_addr,
	input wire logic [IMSW_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [IMSW_DW-1:0] reg_rdata,
	output logic irq,
	input wire logic signed [IMSW_SW-1:0] nco_i0,
	input wire logic signed [IMSW_SW-1:0] nco_q0,
	input wire logic signed [IMSW_SW-1:0] nco_i1,
	input wire logic signed [IMSW_SW-1:0] nco_q1,
	output logic signed [IMSW_OW-1:0] dac0_word,
	output logic signed [IMSW_OW-1:0] dac1_word,
	output logic [3:0] channel_interp_rate,
	output logic [3:0] main_interp_rate,
	output logic [5:0] link_mode,
	output logic [1:0] main_osc_enable,
	output logic [1:0] modulus_synth_enable,
	output logic [1:0] sideband_select
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] page_r, page_nxt; // datapath_page_select
	logic [7:0] link_r, link_nxt; // link mode, bit 7 unused here
	logic [7:0] interp_r, interp_nxt; // interpolation_rate_select
	logic invalid_r, invalid_nxt; // unsupported pairing flag
	logic [3:0] ch_fac_r, ch_fac_nxt; // decoded channel factor
	logic [3:0] main_fac_r, main_fac_nxt; // decoded main factor
	logic [7:0] stat_r, stat_nxt; // sticky events
	logic [7:0] mask_r, mask_nxt; // interrupt mask
	logic irq_r, irq_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [7:0] events; // one-cycle event pulses
	logic [7:0] sw_word; // switch image as written
	logic [7:0] sw_read; // image of the bank that reads return

	imsw_bank_if bank_if ();

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// plain registers; every write to a writable offset lands the same cycle
	always_comb begin
		page_nxt = page_r;
		link_nxt = link_r;
		interp_nxt = interp_r;
		mask_nxt = mask_r;
		if (reg_wr) begin
			case (reg_addr)
				IMSW_ADDR_PAGE: page_nxt = reg_wdata;
				IMSW_ADDR_LINK: link_nxt = reg_wdata & IMSW_LINK_MASK;
				IMSW_ADDR_INTERP: interp_nxt = reg_wdata;
				IMSW_ADDR_MASK: mask_nxt = reg_wdata & IMSW_STAT_MASK;
				default: begin
					// unmapped and read-only offsets ignore writes
				end
			endcase
		end
	end

	// switch image: complex mode forces the route field, whatever was written
	always_comb begin
		sw_word = reg_wdata & IMSW_SWCFG_MASK;
		if (reg_wdata[IMSW_CMPLX_BIT]) begin
			sw_word[IMSW_MODE_LSB +: 2] = IMSW_ROUTE_SUMI;
		end
		bank_if.wr_word = sw_word;
		// each set page bit opens its bank to the write
		bank_if.wr_en = (reg_wr && reg_addr == IMSW_ADDR_SWCFG) ? page_r[1:0] : 2'b00;
	end

	// ----------------------------------------------------------------
	// rate decode and pairing check
	// ----------------------------------------------------------------
	// an undefined code decodes to factor zero and raises the flag
	always_comb begin
		ch_fac_nxt = imsw_factor(interp_nxt[IMSW_CH_LSB +: 4],
			imsw_ch_ok(interp_nxt[IMSW_CH_LSB +: 4]));
		main_fac_nxt = imsw_factor(interp_nxt[IMSW_MAIN_LSB +: 4],
			imsw_main_ok(interp_nxt[IMSW_MAIN_LSB +: 4]));
		// the full mode table is not held here; these are the cases checked
		invalid_nxt = !imsw_ch_ok(interp_nxt[IMSW_CH_LSB +: 4]) ||
			!imsw_main_ok(interp_nxt[IMSW_MAIN_LSB +: 4]) ||
			(interp_nxt[IMSW_MAIN_LSB +: 4] == IMSW_RATE_1X &&
			interp_nxt[IMSW_CH_LSB +: 4] != IMSW_RATE_1X) ||
			(link_nxt[4:0] > IMSW_LINK_MODE_MAX);
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	// a read of status clears it; an event in the same cycle still lands
	always_comb begin
		events = 8'h00;
		events[IMSW_EV_INVALID] = invalid_nxt && !invalid_r;
		events[IMSW_EV_FORCED] = reg_wr && reg_addr == IMSW_ADDR_SWCFG &&
			reg_wdata[IMSW_CMPLX_BIT] && (page_r[1:0] != 2'b00);
		stat_nxt = stat_r;
		if (reg_rd && reg_addr == IMSW_ADDR_STAT) begin
			stat_nxt = 8'h00;
		end
		stat_nxt = stat_nxt | events;
		// level output tracks the registered status and mask together
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// bank 0 answers when its page bit is set, otherwise bank 1
	always_comb begin
		sw_read = page_r[0] ? bank_if.cfg[0] : bank_if.cfg[1];
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				IMSW_ADDR_PAGE: rdata_nxt = page_r;
				IMSW_ADDR_LINK: rdata_nxt = {invalid_r, link_r[6:0]};
				IMSW_ADDR_INTERP: rdata_nxt = interp_r;
				IMSW_ADDR_SWCFG: rdata_nxt = sw_read;
				IMSW_ADDR_STAT: rdata_nxt = stat_r;
				IMSW_ADDR_MASK: rdata_nxt = mask_r;
				default: rdata_nxt = 8'h00; // unmapped reads as zero
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// every control register has a constant after the synchronous reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			page_r <= IMSW_PAGE_RST;
			link_r <= IMSW_LINK_RST;
			interp_r <= IMSW_INTERP_RST;
			invalid_r <= 1'b0;
			ch_fac_r <= IMSW_RATE_4X;
			main_fac_r <= IMSW_RATE_8X;
			stat_r <= 8'h00;
			mask_r <= IMSW_MASK_RST;
			irq_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			page_r <= page_nxt;
			link_r <= link_nxt;
			interp_r <= interp_nxt;
			invalid_r <= invalid_nxt;
			ch_fac_r <= ch_fac_nxt;
			main_fac_r <= main_fac_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	imsw_cfg_bank u_bank (
		.ref_clk(ref_clk),
		.srst(srst),
		.bus(bank_if)
	);

	imsw_mod_switch u_switch (
		.ref_clk(ref_clk),
		.srst(srst),
		.cfg(bank_if),
		.i0(nco_i0),
		.q0(nco_q0),
		.i1(nco_i1),
		.q1(nco_q1),
		.dac0_r(dac0_word),
		.dac1_r(dac1_word)
	);

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_r;
	assign irq = irq_r;
	assign channel_interp_rate = ch_fac_r;
	assign main_interp_rate = main_fac_r;
	assign link_mode = link_r[5:0];
	// per-datapath enables straight from the bank registers
	assign main_osc_enable = {bank_if.cfg[1][IMSW_OSC_BIT], bank_if.cfg[0][IMSW_OSC_BIT]};
	assign modulus_synth_enable = {bank_if.cfg[1][IMSW_MODULUS_BIT],
		bank_if.cfg[0][IMSW_MODULUS_BIT]};
	assign sideband_select = {bank_if.cfg[1][IMSW_SIDEBAND_BIT],
		bank_if.cfg[0][IMSW_SIDEBAND_BIT]};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_wr(logic [11:0] a);
		reg_wr && reg_addr == a;
	endsequence

	sequence s_cmplx_wr;
		s_wr(IMSW_ADDR_SWCFG) ##0 (reg_wdata[6] && page_r[0]);
	endsequence

	a_ch_rate: assert property (s_wr(IMSW_ADDR_INTERP) ##0 reg_wdata[3:0] == 4'h3 |=>
		channel_interp_rate == 4'h3)
		else $error("channel 3x not decoded");
	a_main_rate: assert property (s_wr(IMSW_ADDR_INTERP) ##0 reg_wdata[7:4] == 4'hc |=>
		main_interp_rate == 4'hc && !invalid_r)
		else $error("main 12x not decoded");
	// the event only fires on a rising flag, so start from a clear flag
	a_bad_pair: assert property (s_wr(IMSW_ADDR_INTERP) ##0 (reg_wdata == 8'h14 && !invalid_r) |=>
		invalid_r && stat_r[0])
		else $error("unsupported pairing not flagged");
	a_cmplx_force: assert property (s_cmplx_wr |=>
		bank_if.cfg[0][5:4] == 2'b11 && bank_if.cfg[0][6])
		else $error("complex mode did not force route 0b11");
	a_mode_plain: assert property (s_wr(IMSW_ADDR_SWCFG) ##0 (!reg_wdata[6] && page_r[0]) |=>
		bank_if.cfg[0][5:4] == $past(reg_wdata[5:4]))
		else $error("route mode not as written");
	a_osc_enable: assert property (s_wr(IMSW_ADDR_SWCFG) ##0 page_r[1:0] == 2'b10 |=>
		main_osc_enable[1] == $past(reg_wdata[3]) && $stable(main_osc_enable[0]))
		else $error("nco enable not paged");
	a_modulus_en: assert property (s_wr(IMSW_ADDR_SWCFG) ##0 page_r[0] |=>
		modulus_synth_enable[0] == $past(reg_wdata[2]))
		else $error("modulus enable not stored");
	a_read_timing: assert property (reg_rd && reg_addr == IMSW_ADDR_INTERP |=>
		reg_rdata == interp_r ##1 ($past(reg_rd) || reg_rdata == 8'h00))
		else $error("read data not in the following cycle only");
	a_irq_level: assert property (irq == |(stat_r & mask_r))
		else $error("interrupt level disagrees with status and mask");
endmodule : imsw_cfg_top

// file: hdl/imsw_pkg.sv
/*
 * imsw_pkg: constants, field layout, reset values and decode functions
 * shared by the interpolation / modulator switch configuration block.
 * assumes: one 20 MHz clock domain, 8-bit register port, 12-bit address.
 */
package imsw_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int IMSW_AW = 12; // register address width
	localparam int IMSW_DW = 8; // register data width
	localparam int IMSW_SW = 16; // nco result sample width
	localparam int IMSW_OW = 18; // dac word width, room for a sum of negated q
	localparam int IMSW_PAGES = 2; // one bank per main datapath

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] IMSW_ADDR_PAGE = 12'h008; // datapath page select
	localparam logic [11:0] IMSW_ADDR_LINK = 12'h110; // serial link mode
	localparam logic [11:0] IMSW_ADDR_INTERP = 12'h111; // interpolation_rate_select
	localparam logic [11:0] IMSW_ADDR_SWCFG = 12'h112; // modulator_switch_config
	localparam logic [11:0] IMSW_ADDR_STAT = 12'h120; // sticky event status
	localparam logic [11:0] IMSW_ADDR_MASK = 12'h121; // interrupt mask

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int IMSW_CH_LSB = 0; // channel_interp_rate [3:0]
	localparam int IMSW_MAIN_LSB = 4; // main_interp_rate [7:4]
	localparam int IMSW_CMPLX_BIT = 6; // complex_mod_select
	localparam int IMSW_MODE_LSB = 4; // switch_route_mode [5:4]
	localparam int IMSW_OSC_BIT = 3; // main_osc_enable
	localparam int IMSW_MODULUS_BIT = 2; // modulus_synth_enable
	localparam int IMSW_SIDEBAND_BIT = 1; // sideband_select
	localparam int IMSW_INVALID_BIT = 7; // unsupported pairing flag
	localparam int IMSW_EV_INVALID = 0; // status: pairing became invalid
	localparam int IMSW_EV_FORCED = 1; // status: route mode forced to 0b11
	localparam logic [7:0] IMSW_SWCFG_MASK = 8'h7e; // stored switch bits
	localparam logic [7:0] IMSW_LINK_MASK = 8'h7f; // writable link bits
	localparam logic [7:0] IMSW_STAT_MASK = 8'h03; // implemented events

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] IMSW_PAGE_RST = 8'h03; // writes reach both banks
	localparam logic [7:0] IMSW_LINK_RST = 8'h20;
	localparam logic [7:0] IMSW_INTERP_RST = 8'h84; // main 8x, channel 4x
	localparam logic [7:0] IMSW_SWCFG_RST = 8'h00;
	localparam logic [7:0] IMSW_MASK_RST = 8'h00;
	localparam logic [4:0] IMSW_LINK_MODE_MAX = 5'h16; // highest supported mode

	// ----------------------------------------------------------------
	// rate codes and route modes
	// ----------------------------------------------------------------
	localparam logic [3:0] IMSW_RATE_1X = 4'h1;
	localparam logic [3:0] IMSW_RATE_2X = 4'h2;
	localparam logic [3:0] IMSW_RATE_3X = 4'h3;
	localparam logic [3:0] IMSW_RATE_4X = 4'h4;
	localparam logic [3:0] IMSW_RATE_6X = 4'h6;
	localparam logic [3:0] IMSW_RATE_8X = 4'h8;
	localparam logic [3:0] IMSW_RATE_12X = 4'hc;

	typedef enum logic [1:0] {
		IMSW_ROUTE_SPLIT = 2'b00, // dac0 i0, dac1 i1
		IMSW_ROUTE_SUM = 2'b01, // dac0 i0+i1, dac1 q0+q1
		IMSW_ROUTE_IQ = 2'b10, // dac0 i0, dac1 q0
		IMSW_ROUTE_SUMI = 2'b11 // dac0 i0+i1, dac1 zero
	} imsw_route_t;

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	// channel rate codes that hardware supports
	function automatic logic imsw_ch_ok(input logic [3:0] code);
		imsw_ch_ok = (code == IMSW_RATE_1X) || (code == IMSW_RATE_2X) ||
			(code == IMSW_RATE_3X) || (code == IMSW_RATE_4X) ||
			(code == IMSW_RATE_6X) || (code == IMSW_RATE_8X);
	endfunction : imsw_ch_ok

	// main rate codes that hardware supports
	function automatic logic imsw_main_ok(input logic [3:0] code);
		imsw_main_ok = (code == IMSW_RATE_1X) || (code == IMSW_RATE_2X) ||
			(code == IMSW_RATE_4X) || (code == IMSW_RATE_6X) ||
			(code == IMSW_RATE_8X) || (code == IMSW_RATE_12X);
	endfunction : imsw_main_ok

	// code to interpolation factor; zero for an undefined code
	function automatic logic [3:0] imsw_factor(input logic [3:0] code, input logic ok);
		if (!ok) begin
			imsw_factor = 4'h0;
		end else if (code == IMSW_RATE_12X) begin
			imsw_factor = 4'hc;
		end else begin
			imsw_factor = code;
		end
	endfunction : imsw_factor
endpackage : imsw_pkg

// file: hdl/imsw_bank_if.sv
/*
 * imsw_bank_if: carries the paged switch settings between the register
 * front end, the bank storage and the modulator switch.
 * assumes: all three ends sit on ref_clk.
 */
interface imsw_bank_if;
	logic [1:0] wr_en; // one write enable per bank
	logic [7:0] wr_word; // image written to the selected banks
	logic [1:0][7:0] cfg; // stored image of each bank

	modport ctrl (output wr_en, output wr_word, input cfg);
	modport bank (input wr_en, input wr_word, output cfg);
	modport dp (input cfg);
endinterface : imsw_bank_if

// file: hdl/imsw_cfg_bank.sv
/*
 * imsw_cfg_bank: one switch configuration word per main datapath.
 * assumes: write enables and word come from the register front end,
 * already masked and already forced where complex mode demands it.
 */
module imsw_cfg_bank
	import imsw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	imsw_bank_if.bank bus
);
	// ----------------------------------------------------------------
	// bank storage
	// ----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < IMSW_PAGES; p++) begin : g_page
			logic [7:0] word_r; // stored image of this bank
			logic [7:0] word_nxt;

			// next value: only a write aimed at this page lands here
			always_comb begin
				word_nxt = bus.wr_en[p] ? (bus.wr_word & IMSW_SWCFG_MASK) : word_r;
			end

			// register
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					word_r <= IMSW_SWCFG_RST;
				end else begin
					word_r <= word_nxt;
				end
			end

			assign bus.cfg[p] = word_r;

			// a bank not addressed keeps its word
			a_bank_hold: assert property (@(posedge ref_clk) disable iff (srst)
				!bus.wr_en[p] |=> bus.cfg[p] == $past(bus.cfg[p]))
				else $error("bank changed without a write");
		end
	endgenerate
endmodule : imsw_cfg_bank

// file: hdl/imsw_mod_switch.sv
/*
 * imsw_mod_switch: routes the main nco i/q results to the two dac words.
 * assumes: nco results arrive signed on ref_clk; bank 0 steers the switch,
 * bank 1 supplies the second datapath nco enable and sideband.
 */
module imsw_mod_switch
	import imsw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	imsw_bank_if.dp cfg,
	input wire logic signed [IMSW_SW-1:0] i0,
	input wire logic signed [IMSW_SW-1:0] q0,
	input wire logic signed [IMSW_SW-1:0] i1,
	input wire logic signed [IMSW_SW-1:0] q1,
	output logic signed [IMSW_OW-1:0] dac0_r,
	output logic signed [IMSW_OW-1:0] dac1_r
);
	// ----------------------------------------------------------------
	// routing
	// ----------------------------------------------------------------
	logic signed [IMSW_OW-1:0] i0x, i1x, q0x, q1x; // widened, sideband applied to q0x and q1x
	logic signed [IMSW_OW-1:0] dac0_nxt, dac1_nxt;
	logic cmplx; // complex modulation on datapath 0
	logic osc1; // second datapath nco running
	imsw_route_t mode;

	// next dac words; lower sideband conjugates q, which flips the spectrum
	always_comb begin
		cmplx = cfg.cfg[0][IMSW_CMPLX_BIT];
		osc1 = cfg.cfg[1][IMSW_OSC_BIT];
		mode = imsw_route_t'(cfg.cfg[0][IMSW_MODE_LSB +: 2]);
		i0x = IMSW_OW'(i0);
		i1x = IMSW_OW'(i1);
		q0x = cfg.cfg[0][IMSW_SIDEBAND_BIT] ? -IMSW_OW'(q0) : IMSW_OW'(q0);
		q1x = cfg.cfg[1][IMSW_SIDEBAND_BIT] ? -IMSW_OW'(q1) : IMSW_OW'(q1);
		dac0_nxt = i0x;
		dac1_nxt = i1x;
		if (cmplx && mode == IMSW_ROUTE_SUMI) begin
			// complex pass of both ncos, or nco 0 alone
			dac0_nxt = osc1 ? i0x + i1x : i0x;
			dac1_nxt = osc1 ? q0x + q1x : q0x;
		end else begin
			case (mode)
				IMSW_ROUTE_SPLIT: begin
					dac0_nxt = i0x;
					dac1_nxt = i1x;
				end
				IMSW_ROUTE_SUM: begin
					dac0_nxt = i0x + i1x;
					dac1_nxt = q0x + q1x;
				end
				IMSW_ROUTE_IQ: begin
					dac0_nxt = i0x;
					dac1_nxt = q0x;
				end
				IMSW_ROUTE_SUMI: begin
					dac0_nxt = i0x + i1x;
					dac1_nxt = '0;
				end
				default: begin
					dac0_nxt = '0;
					dac1_nxt = '0;
				end
			endcase
		end
	end

	// register the dac words
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dac0_r <= '0;
			dac1_r <= '0;
		end else begin
			dac0_r <= dac0_nxt;
			dac1_r <= dac1_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_plain(logic [1:0] m);
		!cmplx && mode == m;
	endsequence

	a_route_split: assert property (s_plain(2'b00) |=>
		dac0_r == IMSW_OW'($past(i0)) && dac1_r == IMSW_OW'($past(i1)))
		else $error("split route wrong");
	a_route_sum: assert property (s_plain(2'b01) ##0 (!cfg.cfg[0][1] && !cfg.cfg[1][1]) |=>
		dac0_r == IMSW_OW'($past(i0)) + IMSW_OW'($past(i1)) &&
		dac1_r == IMSW_OW'($past(q0)) + IMSW_OW'($past(q1)))
		else $error("sum route wrong");
	a_route_iq: assert property (s_plain(2'b10) ##0 !cfg.cfg[0][1] |=>
		dac0_r == IMSW_OW'($past(i0)) && dac1_r == IMSW_OW'($past(q0)))
		else $error("iq route wrong");
	a_route_zero: assert property (s_plain(2'b11) |=> dac1_r == '0)
		else $error("dac1 not held at zero");
	a_cmplx_dual: assert property (cmplx && mode == 2'b11 && osc1 && !cfg.cfg[1][1] &&
		!cfg.cfg[0][1] |=> dac1_r == IMSW_OW'($past(q0)) + IMSW_OW'($past(q1)))
		else $error("complex dual route wrong");
	a_cmplx_single: assert property (cmplx && mode == 2'b11 && !osc1 && !cfg.cfg[0][1] |=>
		dac0_r == IMSW_OW'($past(i0)) && dac1_r == IMSW_OW'($past(q0)))
		else $error("complex single route wrong");
	a_lower_sideband: assert property (s_plain(2'b10) ##0 cfg.cfg[0][1] |=>
		dac1_r == -IMSW_OW'($past(q0)))
		else $error("lower sideband not inverted");
endmodule : imsw_mod_switch

// file: testbench/interp_and_modulator_switch_cfg_bench.sv
/* bench for imsw_cfg_top: register tasks, rate, route, bank and irq tests.
 * assumes: design assertions live in hdl; one 20 MHz clock, sync reset. */
module interp_and_modulator_switch_cfg_bench import imsw_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic srst = 1'b1; // held for two edges
	logic [IMSW_AW-1:0] reg_addr = '0;
	logic [IMSW_DW-1:0] reg_wdata = '0, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, irq;
	// fixed nco results, as a zero tuning word gives
	logic signed [IMSW_SW-1:0] nco_i0 = 16'h0100, nco_q0 = 16'h0020;
	logic signed [IMSW_SW-1:0] nco_i1 = 16'h0200, nco_q1 = 16'h0040;
	logic signed [IMSW_OW-1:0] dac0_word, dac1_word;
	logic [3:0] channel_interp_rate, main_interp_rate;
	logic [5:0] link_mode;
	logic [1:0] main_osc_enable, modulus_synth_enable, sideband_select;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	logic [3:0] mc [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hc}; // main codes
	logic [3:0] cc [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8}; // channel codes
	logic [17:0] e0 [4] = '{18'h100, 18'h300, 18'h100, 18'h300}; // dac0 per mode
	logic [17:0] e1 [4] = '{18'h200, 18'h060, 18'h020, 18'h000}; // dac1 per mode

	imsw_cfg_top dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.irq, .nco_i0, .nco_q0, .nco_i1, .nco_q1, .dac0_word, .dac1_word,
		.channel_interp_rate, .main_interp_rate, .link_mode, .main_osc_enable,
		.modulus_synth_enable, .sideband_select);

	// ----------------------------------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------------------------------
	// free running 50 ns clock
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	// tests need well under 1000 cycles; a hang is cut at 4000
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			test_done();
		end
	end
	// compare with case inequality so an unknown never matches
	task automatic chk(input string what, input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// one-cycle write strobe; a dead cycle follows before the next access
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe, so look there
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(what, 18'(reg_rdata), 18'(exp));
	endtask : rd
	// let registered outputs land before looking at them
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		#1 chk("rates", 18'({main_interp_rate, channel_interp_rate}), 18'h84);
		chk("link", 18'(link_mode), 18'h20);
		rd(IMSW_ADDR_INTERP, 8'h84, "interp reg");
		rd(IMSW_ADDR_SWCFG, 8'h00, "swcfg reg");
		$display("test reset done");
		// every listed rate code, paired so the combination stays valid
		for (int i = 0; i < 6; i++) begin
			wr(IMSW_ADDR_INTERP, {mc[i], cc[i]});
			settle();
			chk("main rate", 18'(main_interp_rate), 18'(mc[i]));
			chk("ch rate", 18'(channel_interp_rate), 18'(cc[i]));
		end
		// listed codes, but main 1x with channel 4x is not a supported pairing
		wr(IMSW_ADDR_INTERP, 8'h14);
		settle();
		chk("pair ch rate", 18'(channel_interp_rate), 18'h4);
		rd(IMSW_ADDR_LINK, 8'ha0, "flag up");
		wr(IMSW_ADDR_INTERP, 8'h84);
		rd(IMSW_ADDR_LINK, 8'h20, "flag down");
		rd(IMSW_ADDR_STAT, 8'h01, "status");
		rd(IMSW_ADDR_STAT, 8'h00, "status clr");
		$display("test rates done");
		// all four route modes with the complex bit clear
		for (int m = 0; m < 4; m++) begin
			wr(IMSW_ADDR_SWCFG, 8'(m) << 4);
			settle();
			chk("dac0", dac0_word, e0[m]);
			chk("dac1", dac1_word, e1[m]);
		end
		wr(IMSW_ADDR_SWCFG, 8'h2e);
		settle();
		chk("en on", 18'({main_osc_enable, modulus_synth_enable, sideband_select}), 18'h3f);
		chk("dac1 lsb", dac1_word, 18'h3ffe0);
		wr(IMSW_ADDR_SWCFG, 8'h00);
		settle();
		chk("en off", 18'({main_osc_enable, modulus_synth_enable, sideband_select}), 18'h0);
		$display("test routes done");
		// complex write forces mode 11; event masked, then unmasked
		wr(IMSW_ADDR_MASK, 8'h01);
		wr(IMSW_ADDR_SWCFG, 8'h48);
		settle();
		chk("irq masked", 18'(irq), 18'h0);
		wr(IMSW_ADDR_MASK, 8'h02);
		settle();
		chk("irq", 18'(irq), 18'h1);
		rd(IMSW_ADDR_SWCFG, 8'h78, "forced");
		chk("dac0 cplx", dac0_word, 18'h300);
		chk("dac1 cplx", dac1_word, 18'h060);
		rd(IMSW_ADDR_STAT, 8'h02, "status");
		settle();
		chk("irq clr", 18'(irq), 18'h0);
		$display("test complex done");
		// second bank only: its nco off leaves nco0 on both dacs
		wr(IMSW_ADDR_PAGE, 8'h02);
		wr(IMSW_ADDR_SWCFG, 8'h00);
		settle();
		chk("osc banks", 18'(main_osc_enable), 18'h1);
		chk("dac0 nco0", dac0_word, 18'h100);
		chk("dac1 nco0", dac1_word, 18'h020);
		rd(IMSW_ADDR_SWCFG, 8'h00, "bank1");
		wr(IMSW_ADDR_PAGE, 8'h01);
		rd(IMSW_ADDR_SWCFG, 8'h78, "bank0");
		rd(12'h0ff, 8'h00, "unmapped");
		$display("test banks done");
		test_done();
	end
endmodule : interp_and_modulator_switch_cfg_bench
